// *** inc/smbh_pkg.sv ***
// Constants, commands and states of the two-wire bus master controller.
// Assumes a 10 MHz system clock; no bus of its own toward software.
package smbh_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 100;
    localparam int NS_PER_MS       = 1000000;
    localparam int LOW_TIMEOUT_MS  = 25;
    // Least time: rounded up
    localparam int LOW_TIMEOUT_CYC =
        (LOW_TIMEOUT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_LIMIT_MS  = 10;
    // Longest time: rounded down
    localparam int RESET_LIMIT_CYC =
        (RESET_LIMIT_MS * NS_PER_MS) / CLK_PERIOD_NS;
    localparam int BIT_RATE_DIV    = 20;
    localparam int TICK_CYC_DEF    = 10;
    localparam int FREE_TICKS      = 10;
    localparam int SDA_HOLD_CYC    = 3;

    // ==========================================================
    // Byte layout
    localparam int         BYTE_BITS    = 8;
    localparam logic [3:0] ACK_SLOT     = 4'h8;
    localparam int         ADDR_DIR_BIT = 0;
    localparam logic       DIR_READ     = 1'b1;
    localparam logic       DIR_WRITE    = 1'b0;

    // ==========================================================
    // Commands and states
    typedef enum logic [1:0] {
        SMBH_CMD_START = 2'b00,
        SMBH_CMD_WRITE = 2'b01,
        SMBH_CMD_READ  = 2'b10,
        SMBH_CMD_STOP  = 2'b11
    } smbh_cmd_e;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_WAIT_FREE = 4'b0001,
        ST_START_A   = 4'b0010,
        ST_START_B   = 4'b0011,
        ST_HOLD      = 4'b0100,
        ST_BIT_LOW   = 4'b0101,
        ST_BIT_HIGH  = 4'b0110,
        ST_STOP_A    = 4'b0111,
        ST_STOP_B    = 4'b1000,
        ST_RS_A      = 4'b1001,
        ST_RS_B      = 4'b1010
    } smbh_st_e;

endpackage

// *** core/smbh_line_sync.sv ***
// Synchronises the two bus lines and finds START and STOP on them.
// Assumes both lines idle high; inputs are asynchronous pin levels.
`timescale 1ns/1ps
module smbh_line_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    // Synchronised view
    output logic      scl_s,
    output logic      sda_s,
    output logic      start_det,
    output logic      stop_det
);
    logic [1:0] scl_ff_q;
    logic [1:0] sda_ff_q;
    logic       sda_prev_q;

    // ==========================================================
    // Two-stage synchronisers, idle value high
    always_ff @(posedge clk) begin
        if (reset) begin
            scl_ff_q <= 2'h3;
            sda_ff_q <= 2'h3;
        end else begin
            scl_ff_q <= {scl_ff_q[0], scl_in};
            sda_ff_q <= {sda_ff_q[0], sda_in};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sda_prev_q <= 1'b1;
        end else begin
            sda_prev_q <= sda_ff_q[1];
        end
    end

    assign scl_s = scl_ff_q[1];
    assign sda_s = sda_ff_q[1];

    // ==========================================================
    // SDA moving while SCL is high marks START or STOP
    assign start_det = scl_s && sda_prev_q && !sda_s;
    assign stop_det  = scl_s && !sda_prev_q && sda_s;

endmodule // smbh_line_sync

// *** core/smbh_master.sv ***
// Two-wire bus master that drives an SMBus/I2C-compatible device.
// Assumes open-drain SCL and SDA with pull-ups outside this block.
// Overview of operation
// - START, address plus direction, data, STOP
// - Direction bit one reads, zero writes
// - Receiver pulls SDA low in ninth pulse
// - Write: byte then wait slave acknowledge
// - Read: slave byte then master acknowledge
// - Master ends transfer with STOP
// - Sender owns SDA; receiver owns acknowledge
// - Master starts transfers, supplies all clocks
// - Slave may stretch; master waits SCL high
// - SCL low over 25 ms resets communication
// - Software sets timer for 25 ms; here TIMEOUT_CYC fixes it and I_SCL_LOW_TIMEOUT_EN only enables it
// - Lines only pulled low or released
`timescale 1ns/1ps
module smbh_master
    import smbh_pkg::*;
#(
    parameter int TICK_CYC    = TICK_CYC_DEF,
    parameter int TIMEOUT_CYC = LOW_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic       I_CLK,
    input  wire logic       I_RESET,
    // Configuration
    input  wire logic       I_ENABLE,
    input  wire logic       I_SCL_LOW_TIMEOUT_EN,
    input  wire logic       I_BUS_FREE_TIMEOUT_EN,
    // Command port
    input  wire logic       I_CMD_VALID,
    input  wire logic [1:0] I_CMD,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_NACK,
    output logic            O_CMD_READY,
    output logic            O_DONE,
    output logic [7:0]      O_RDATA,
    output logic            O_ACK_IN,
    output logic            O_ARB_LOST,
    output logic            O_TIMEOUT,
    output logic            O_BUS_BUSY,
    output logic            O_READ_MODE,
    // Bus pins
    input  wire logic       I_SCL,
    output logic            O_SCL_O,
    output logic            O_SCL_OE,
    input  wire logic       I_SDA,
    output logic            O_SDA_O,
    output logic            O_SDA_OE
);
    localparam int PW = $clog2(TICK_CYC + 1);
    localparam int TW = $clog2(TIMEOUT_CYC + 1);
    localparam int FW = $clog2(FREE_TICKS * TICK_CYC + 2);
    localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYC - 1);
    localparam logic [PW-1:0] HOLD_AT   = PW'(SDA_HOLD_CYC);
    localparam logic [TW-1:0] TO_LAST   = TW'(TIMEOUT_CYC - 1);
    localparam logic [FW-1:0] FREE_AT   = FW'(FREE_TICKS * TICK_CYC + 1);

    // Two ticks must span at least BIT_RATE_DIV cycles and SDA must settle inside low
    initial begin
        if (2 * TICK_CYC < BIT_RATE_DIV || TICK_CYC <= SDA_HOLD_CYC)
            $error("TICK_CYC too small");
        if (TIMEOUT_CYC < 2)
            $error("TIMEOUT_CYC too small");
    end

    smbh_st_e       st_q;
    smbh_st_e       st_d;
    logic [PW-1:0]  ph_q;
    logic [3:0]     bit_q;
    logic [7:0]     shift_q;
    logic           rd_op_q;
    logic           nack_q;
    logic           first_q;
    logic [TW-1:0]  low_cnt_q;
    logic [FW-1:0]  free_cnt_q;
    logic           scl_s;
    logic           sda_s;
    logic           start_det;
    logic           stop_det;
    logic           cnt_en;
    logic           tick;
    logic           take;
    logic           timeout;
    logic           arb_lose;
    logic           tx_bit;

    smbh_line_sync u_sync (
        .clk       (I_CLK),
        .reset     (I_RESET),
        .scl_in    (I_SCL),
        .sda_in    (I_SDA),
        .scl_s     (scl_s),
        .sda_s     (sda_s),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    // Whether this end pulls SDA low for the given bit slot
    function automatic logic pull_low(input logic rd, input logic [3:0] b,
                                      input logic msb, input logic nack);
        if (b == ACK_SLOT)
            pull_low = rd && !nack;
        else
            pull_low = !rd && !msb;
    endfunction

    // ==========================================================
    // Phase divider: ST_BIT_HIGH, ST_STOP_B and ST_RS_B count only once SCL reads high; ST_START_A always counts
    assign cnt_en = (st_q == ST_BIT_HIGH || st_q == ST_STOP_B ||
                     st_q == ST_RS_B) ? scl_s : 1'b1;
    assign tick = cnt_en && (ph_q == TICK_LAST);
    assign take = O_CMD_READY && I_CMD_VALID;
    assign tx_bit = !rd_op_q && (bit_q != ACK_SLOT);
    assign timeout = I_SCL_LOW_TIMEOUT_EN && !scl_s &&
                     (low_cnt_q == TO_LAST);
    // Released SDA seen low while sending means another master won
    assign arb_lose = (st_q == ST_BIT_HIGH) && tick && tx_bit &&
                      !O_SDA_OE && !sda_s;
    assign O_CMD_READY = I_ENABLE &&
                         (st_q == ST_IDLE || st_q == ST_HOLD);
    assign O_SCL_O = 1'b0;
    assign O_SDA_O = 1'b0;

    // ==========================================================
    // Sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (take && I_CMD == SMBH_CMD_START)
                    st_d = ST_WAIT_FREE;
            end
            ST_WAIT_FREE: begin
                if (!O_BUS_BUSY && scl_s && sda_s)
                    st_d = ST_START_A;
            end
            ST_START_A: if (tick) st_d = ST_START_B;
            ST_START_B: if (tick) st_d = ST_HOLD;
            ST_HOLD: begin
                if (take) begin
                    case (I_CMD)
                        SMBH_CMD_START: st_d = ST_RS_A;
                        SMBH_CMD_STOP:  st_d = ST_STOP_A;
                        default:        st_d = ST_BIT_LOW;
                    endcase
                end
            end
            ST_BIT_LOW: if (tick) st_d = ST_BIT_HIGH;
            ST_BIT_HIGH: begin
                if (arb_lose)
                    st_d = ST_IDLE;
                else if (tick)
                    st_d = (bit_q == ACK_SLOT) ? ST_HOLD : ST_BIT_LOW;
            end
            ST_STOP_A: if (tick) st_d = ST_STOP_B;
            ST_STOP_B: if (tick) st_d = ST_IDLE;
            ST_RS_A:   if (tick) st_d = ST_RS_B;
            ST_RS_B:   if (tick) st_d = ST_START_A;
            default:   st_d = ST_IDLE;
        endcase
        if (timeout || !I_ENABLE)
            st_d = ST_IDLE;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) st_q <= ST_IDLE;
        else         st_q <= st_d;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET || st_d != st_q) ph_q <= '0;
        else if (cnt_en && ph_q != TICK_LAST) ph_q <= ph_q + 1'b1;
    end

    // ==========================================================
    // Line drivers, registered; only pull low or release
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_SCL_OE <= 1'b0;
        end else begin
            case (st_d)
                ST_START_B, ST_HOLD, ST_BIT_LOW, ST_STOP_A, ST_RS_A:
                    O_SCL_OE <= 1'b1;
                default:
                    O_SCL_OE <= 1'b0;
            endcase
        end
    end

    // Data, STOP and repeated-START levels on SDA change only a hold time after SCL fell
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_SDA_OE <= 1'b0;
        end else if (st_d == ST_IDLE || st_d == ST_WAIT_FREE) begin
            O_SDA_OE <= 1'b0;
        end else if (st_d == ST_START_A) begin
            O_SDA_OE <= 1'b1;
        end else if (st_q == ST_BIT_LOW && ph_q == HOLD_AT) begin
            O_SDA_OE <= pull_low(rd_op_q, bit_q, shift_q[7],
                                 nack_q);
        end else if (st_q == ST_STOP_A && ph_q == HOLD_AT) begin
            O_SDA_OE <= 1'b1;
        end else if (st_q == ST_RS_A && ph_q == HOLD_AT) begin
            O_SDA_OE <= 1'b0;
        end
    end

    // ==========================================================
    // Byte shifting and operation bookkeeping
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            shift_q <= 8'h00;
            bit_q   <= 4'h0;
            rd_op_q <= 1'b0;
            nack_q  <= 1'b0;
        end else if (st_q == ST_HOLD && take) begin
            shift_q <= I_WDATA;
            bit_q   <= 4'h0;
            rd_op_q <= (I_CMD == SMBH_CMD_READ);
            nack_q  <= I_NACK;
        end else if (st_q == ST_BIT_HIGH && tick) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q != ACK_SLOT)
                shift_q <= {shift_q[6:0], sda_s};
        end
    end

    // The first byte after a START carries address and direction
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            first_q     <= 1'b0;
            O_READ_MODE <= DIR_WRITE;
        end else if (st_q == ST_START_B) begin
            first_q <= 1'b1;
        end else if (st_q == ST_HOLD && take) begin
            first_q <= 1'b0;
            if (first_q && I_CMD == SMBH_CMD_WRITE)
                O_READ_MODE <= (I_WDATA[ADDR_DIR_BIT] == DIR_READ);
        end
    end

    // ==========================================================
    // Results; the acknowledge is sampled while SCL is high
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_DONE     <= 1'b0;
            O_ARB_LOST <= 1'b0;
            O_TIMEOUT  <= 1'b0;
            O_RDATA    <= 8'h00;
            O_ACK_IN   <= 1'b0;
        end else begin
            O_DONE     <= (st_q == ST_START_B && tick) ||
                          (st_q == ST_STOP_B && tick) || arb_lose ||
                          (st_q == ST_BIT_HIGH && tick &&
                           bit_q == ACK_SLOT);
            O_ARB_LOST <= arb_lose;
            O_TIMEOUT  <= timeout;
            if (st_q == ST_BIT_HIGH && tick && bit_q == ACK_SLOT) begin
                O_ACK_IN <= !sda_s;
                if (rd_op_q)
                    O_RDATA <= shift_q;
            end
        end
    end

    // ==========================================================
    // Bus watch: SCL-low timer and busy/free tracking
    always_ff @(posedge I_CLK) begin
        if (I_RESET || scl_s || !I_SCL_LOW_TIMEOUT_EN) low_cnt_q <= '0;
        else if (low_cnt_q != TO_LAST) low_cnt_q <= low_cnt_q + 1'b1;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET || !(scl_s && sda_s)) free_cnt_q <= '0;
        else if (free_cnt_q != FREE_AT) free_cnt_q <= free_cnt_q + 1'b1;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET)
            O_BUS_BUSY <= 1'b0;
        else if (start_det)
            O_BUS_BUSY <= 1'b1;
        else if (stop_det || (I_BUS_FREE_TIMEOUT_EN &&
                              free_cnt_q == FREE_AT))
            O_BUS_BUSY <= 1'b0;
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    property p_idle_released;
        (st_q == ST_IDLE && $past(st_q) == ST_IDLE) |->
            !O_SCL_OE && !O_SDA_OE;
    endproperty
    a_idle_released: assert property (p_idle_released)
        else $error("lines driven while idle");

    property p_stretch;
        (st_q == ST_BIT_HIGH && !scl_s && !timeout && I_ENABLE) |=>
            st_q == ST_BIT_HIGH;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("bit advanced while SCL low");

    property p_write_ack_released;
        (st_q == ST_BIT_HIGH && !rd_op_q && bit_q == ACK_SLOT) |->
            !O_SDA_OE;
    endproperty
    a_write_ack_released: assert property (p_write_ack_released)
        else $error("SDA held in slave acknowledge slot");

    property p_read_released;
        (st_q == ST_BIT_HIGH && rd_op_q && bit_q != ACK_SLOT) |->
            !O_SDA_OE;
    endproperty
    a_read_released: assert property (p_read_released)
        else $error("SDA held while slave sends");

    property p_ack_done;
        (st_q == ST_BIT_HIGH && tick && bit_q == ACK_SLOT && !timeout &&
         I_ENABLE) |=> O_DONE && st_q == ST_HOLD && O_ACK_IN == !$past(sda_s);
    endproperty
    a_ack_done: assert property (p_ack_done)
        else $error("byte end not reported after acknowledge");

    property p_timeout_reset;
        timeout |=> O_TIMEOUT && st_q == ST_IDLE ##1 !O_SCL_OE && !O_SDA_OE;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset)
        else $error("no reset after SCL low timeout");

    property p_stop_seq;
        (st_q == ST_STOP_B && tick && !timeout && I_ENABLE) |->
            O_SDA_OE && !O_SCL_OE ##1 !O_SDA_OE && O_DONE;
    endproperty
    a_stop_seq: assert property (p_stop_seq)
        else $error("STOP not formed with SCL high");

    property p_clock_low;
        (st_q == ST_BIT_LOW && $past(st_q) == ST_BIT_LOW) |-> O_SCL_OE;
    endproperty
    a_clock_low: assert property (p_clock_low)
        else $error("master not holding SCL low");

    property p_start_form;
        (st_q == ST_START_A && $past(st_q) == ST_START_A) |->
            O_SDA_OE && !O_SCL_OE;
    endproperty
    a_start_form: assert property (p_start_form)
        else $error("START not formed with SCL released");

    property p_low_len;
        (st_q == ST_BIT_LOW && ph_q < TICK_LAST && !timeout && I_ENABLE)
            |=> st_q == ST_BIT_LOW;
    endproperty
    a_low_len: assert property (p_low_len)
        else $error("SCL low phase too short");

    c_write: cover property (st_q == ST_BIT_HIGH && tick && !rd_op_q &&
                             bit_q == ACK_SLOT);
    c_read: cover property (st_q == ST_BIT_HIGH && tick && rd_op_q &&
                            bit_q == ACK_SLOT);
    c_arb: cover property (arb_lose);
    c_stop: cover property (st_q == ST_STOP_B && tick);

endmodule // smbh_master

// *** bench/smbh_slave_model.sv ***
// Behavioural two-wire slave device facing the bus master controller.
// Assumes the bench resolves both lines as open-drain with pull-ups.
`timescale 1ns/1ps
module smbh_slave_model #(
    parameter logic [6:0] ADDR     = 7'h2a,
    parameter int         HOLD_NS  = 300,
    parameter int         STRCH_NS = 3000
) (
    // Resolved lines
    input  wire logic scl,
    input  wire logic sda,
    // Behaviour control
    input  wire logic stretch_en,
    // Pulls, high drives the line low
    output logic      scl_pull = 1'b0,
    output logic      sda_pull = 1'b0
);
    // ==========================================================
    // Byte engine, driven by events on the resolved lines
    logic [7:0] mem_q = 8'h00;
    logic [7:0] sh_q  = 8'h00;
    logic [3:0] bit_q = 4'h0;
    logic       act_q = 1'b0, adr_q = 1'b0, tx_q = 1'b0;
    logic       rd_q  = 1'b0, mack_q = 1'b0;

    always @(negedge sda) begin
        if (scl === 1'b1) begin
            act_q = 1'b1;
            adr_q = 1'b1;
            tx_q  = 1'b0;
            bit_q = 4'hf;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1) begin
            act_q    = 1'b0;
            sda_pull = 1'b0;
        end
    end

    always @(posedge scl) begin
        if (act_q && !tx_q && bit_q < 4'h8)
            sh_q = {sh_q[6:0], sda};
        if (act_q && tx_q && bit_q == 4'h8)
            mack_q = !sda;
    end

    // Only lines pulled low or released, never driven high
    always @(negedge scl) begin
        if (act_q) begin
            scl_pull = stretch_en;
            #(HOLD_NS);
            if (bit_q == 4'hf) begin
                bit_q = 4'h0;
            end else if (bit_q == 4'h7) begin
                bit_q = 4'h8;
                if (tx_q)
                    sda_pull = 1'b0;
                else if (adr_q && sh_q[7:1] != ADDR)
                    act_q = 1'b0;
                else begin
                    sda_pull = 1'b1;
                    if (adr_q)
                        rd_q = sh_q[0];
                    else
                        mem_q = sh_q;
                end
            end else if (bit_q == 4'h8) begin
                bit_q    = 4'h0;
                sda_pull = 1'b0;
                if (adr_q)
                    tx_q = rd_q;
                else if (tx_q && !mack_q)
                    act_q = 1'b0;
                adr_q = 1'b0;
                if (act_q && tx_q) begin
                    sh_q     = mem_q;
                    mem_q    = mem_q + 8'h01;
                    sda_pull = !sh_q[7];
                end
            end else begin
                bit_q = bit_q + 4'h1;
                if (tx_q)
                    sda_pull = !sh_q[3'h7 - bit_q[2:0]];
            end
            // Delay only when stretching, else the next fall is missed
            if (scl_pull) begin
                #(STRCH_NS);
                scl_pull = 1'b0;
            end
        end
    end
endmodule // smbh_slave_model

// *** bench/tb.sv ***
// Self-checking bench for the two-wire bus master controller.
// Assumes smbh_pkg and smbh_slave_model are compiled before it.
`timescale 1ns/1ps
module tb
    import smbh_pkg::*;
();
    // ==========================================================
    // Stimulus, bus and bookkeeping
    localparam int         TO_CYC = 200;
    localparam int         LIMIT  = 40000;
    localparam logic [6:0] ADDR   = 7'h2a;
    logic       I_CLK     = 1'b0;
    logic       I_RESET   = 1'b1;
    logic       cmd_valid = 1'b0;
    logic       nack      = 1'b0;
    logic [1:0] cmd       = 2'h0;
    logic [7:0] wdata     = 8'h00;
    logic       tb_scl    = 1'b0;
    logic       tb_sda    = 1'b0;
    logic       stretch   = 1'b0;
    logic       scl_d     = 1'b1;
    logic       O_CMD_READY, O_DONE, O_ACK_IN, O_ARB_LOST, O_TIMEOUT;
    logic       O_BUS_BUSY, O_READ_MODE, O_SCL_OE, O_SDA_OE;
    logic       O_SCL_O, O_SDA_O;
    logic       m_scl, m_sda, arb_seen;
    logic [7:0] O_RDATA;
    int         error_cnt = 0;
    int         tests_run = 0;
    int         cyc = 0;
    int         low_cnt = 0;
    int         per_cnt = 0;
    int         min_per = 1000;
    wire logic  scl_w = !(O_SCL_OE | m_scl | tb_scl);
    wire logic  sda_w = !(O_SDA_OE | m_sda | tb_sda);

    always #(CLK_PERIOD_NS / 2) I_CLK = ~I_CLK;

    smbh_master #(
        .TICK_CYC              (TICK_CYC_DEF),
        .TIMEOUT_CYC           (TO_CYC)
    ) dut_u (
        .I_CLK                 (I_CLK),
        .I_RESET               (I_RESET),
        .I_ENABLE              (1'b1),
        .I_SCL_LOW_TIMEOUT_EN  (1'b1),
        .I_BUS_FREE_TIMEOUT_EN (1'b1),
        .I_CMD_VALID           (cmd_valid),
        .I_CMD                 (cmd),
        .I_WDATA               (wdata),
        .I_NACK                (nack),
        .O_CMD_READY           (O_CMD_READY),
        .O_DONE                (O_DONE),
        .O_RDATA               (O_RDATA),
        .O_ACK_IN              (O_ACK_IN),
        .O_ARB_LOST            (O_ARB_LOST),
        .O_TIMEOUT             (O_TIMEOUT),
        .O_BUS_BUSY            (O_BUS_BUSY),
        .O_READ_MODE           (O_READ_MODE),
        .I_SCL                 (scl_w),
        .O_SCL_O               (O_SCL_O),
        .O_SCL_OE              (O_SCL_OE),
        .I_SDA                 (sda_w),
        .O_SDA_O               (O_SDA_O),
        .O_SDA_OE              (O_SDA_OE)
    );

    smbh_slave_model #(.ADDR(ADDR)) slv_u (
        .scl        (scl_w),
        .sda        (sda_w),
        .stretch_en (stretch),
        .scl_pull   (m_scl),
        .sda_pull   (m_sda)
    );

    // ==========================================================
    // Line monitor and hang guard
    always @(posedge I_CLK) begin
        scl_d   <= scl_w;
        low_cnt <= scl_w ? 0 : low_cnt + 1;
        per_cnt <= (scl_w && !scl_d) ? 1 : per_cnt + 1;
        if (scl_w && !scl_d && per_cnt < min_per)
            min_per <= per_cnt;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            close_out();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Ready only falls on a taken command, so once seen high it is not sampled again
    task automatic do_cmd(input logic [1:0] c, input logic [7:0] d,
                          input logic nk = 1'b0, input bit w = 1'b1);
        int n;
        n = 0;
        while (O_CMD_READY !== 1'b1)
            @(negedge I_CLK);
        @(posedge I_CLK);
        cmd_valid <= 1'b1;
        cmd       <= c;
        wdata     <= d;
        nack      <= nk;
        @(posedge I_CLK);
        cmd_valid <= 1'b0;
        arb_seen = 1'b0;
        while (w && n < 3000) begin
            @(negedge I_CLK);
            n++;
            if (O_DONE === 1'b1) begin
                arb_seen = O_ARB_LOST;
                n = 5000;
            end
        end
        if (w)
            check(8'(n == 5000), 8'h01);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (O_BUS_BUSY !== 1'b0 && n < 300) begin
            @(negedge I_CLK);
            n++;
        end
        check(8'(O_BUS_BUSY), 8'h00);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_write(input logic st, input logic [7:0] d);
        @(posedge I_CLK);
        stretch <= st;
        do_cmd(SMBH_CMD_START, 8'h00);
        do_cmd(SMBH_CMD_WRITE, {ADDR, DIR_WRITE});
        check(8'(O_ACK_IN), 8'h01);
        check(8'(O_READ_MODE), 8'h00);
        do_cmd(SMBH_CMD_WRITE, d);
        check(8'(O_ACK_IN), 8'h01);
        check(slv_u.mem_q, d);
        do_cmd(SMBH_CMD_STOP, 8'h00);
        wait_idle();
    endtask

    task automatic t_read();
        do_cmd(SMBH_CMD_START, 8'h00);
        do_cmd(SMBH_CMD_WRITE, {ADDR, DIR_READ});
        check(8'(O_READ_MODE), 8'h01);
        do_cmd(SMBH_CMD_READ, 8'h00, 1'b0);
        check(O_RDATA, 8'ha5);
        check(8'(slv_u.mack_q), 8'h01);
        do_cmd(SMBH_CMD_READ, 8'h00, 1'b1);
        check(O_RDATA, 8'ha6);
        check(8'(slv_u.mack_q), 8'h00);
        do_cmd(SMBH_CMD_STOP, 8'h00);
        do_cmd(SMBH_CMD_START, 8'h00);
        do_cmd(SMBH_CMD_WRITE, {7'h11, DIR_WRITE});
        check(8'(O_ACK_IN), 8'h00);
        do_cmd(SMBH_CMD_START, 8'h00);
        check(8'(slv_u.act_q), 8'h01);
        do_cmd(SMBH_CMD_STOP, 8'h00);
        wait_idle();
    endtask

    task automatic t_busy();
        @(posedge I_CLK);
        tb_sda <= 1'b1;
        repeat (6) @(negedge I_CLK);
        check(8'(O_BUS_BUSY), 8'h01);
        do_cmd(SMBH_CMD_START, 8'h00, 1'b0, 1'b0);
        repeat (100) @(negedge I_CLK);
        check({6'h0, O_SCL_OE, O_SDA_OE}, 8'h00);
        @(posedge I_CLK);
        tb_sda <= 1'b0;
        do_cmd(SMBH_CMD_STOP, 8'h00);
    endtask

    task automatic t_arb();
        do_cmd(SMBH_CMD_START, 8'h00);
        @(posedge I_CLK);
        tb_sda <= 1'b1;
        do_cmd(SMBH_CMD_WRITE, 8'hff);
        check(8'(arb_seen), 8'h01);
        @(negedge I_CLK);
        check({6'h0, O_SCL_OE, O_SDA_OE}, 8'h00);
        @(posedge I_CLK);
        tb_sda <= 1'b0;
        wait_idle();
    endtask

    task automatic t_timeout();
        int n;
        n = 0;
        do_cmd(SMBH_CMD_START, 8'h00);
        @(posedge I_CLK);
        tb_scl <= 1'b1;
        do_cmd(SMBH_CMD_WRITE, {ADDR, DIR_WRITE}, 1'b0, 1'b0);
        while (O_TIMEOUT !== 1'b1 && n < 400) begin
            @(negedge I_CLK);
            n++;
        end
        check(8'(low_cnt >= TO_CYC && low_cnt <= TO_CYC + 8),
              8'h01);
        check({6'h0, O_SCL_OE, O_SDA_OE}, 8'h00);
        @(posedge I_CLK);
        tb_scl <= 1'b0;
        repeat (50) @(negedge I_CLK);
        check(8'(O_BUS_BUSY), 8'h01);
        wait_idle();
    endtask

    initial begin
        repeat (10) @(posedge I_CLK);
        I_RESET <= 1'b0;
        @(negedge I_CLK);
        check({5'h0, O_SCL_OE, O_SDA_OE, O_BUS_BUSY}, 8'h00);
        check({6'h0, O_SCL_O, O_SDA_O}, 8'h00);
        t_write(1'b1, 8'h3c);
        t_write(1'b0, 8'ha5);
        t_read();
        t_busy();
        t_arb();
        t_timeout();
        check(8'(min_per >= BIT_RATE_DIV && min_per < 100),
              8'h01);
        close_out();
    end
endmodule // tb
